//--- bench/periph_model.sv
// peripheral responder on the far side of the decoder's register buses
// assumes read data is sampled while a bus request is high
`timescale 1ns/10ps
module periph_model (
	input wire logic clk_i,
	input wire logic ahb_req_i,
	input wire logic apb_req_i,
	input wire logic [31:0] addr_i,
	output logic [31:0] rdata_o
);
	logic [31:0] noise_q = 32'h0;
	// an idle bus never holds its last word, so a late sample reads junk
	always_ff @(posedge clk_i)
		noise_q <= noise_q + 32'h0101_0101;
	assign rdata_o = (ahb_req_i | apb_req_i) ? (addr_i ^ 32'h5a5a_0000) : noise_q;
endmodule

//--- bench/test_memory_map_remap_decoder.sv
// self-checking bench for the memory map decoder
// assumes one access at a time, each waited out before the next
`timescale 1ns/10ps
module test_memory_map_remap_decoder;
	logic clk = 1'b0, rst = 1'b1, req = 1'b0, wr = 1'b0, ld = 1'b0, unl = 1'b0;
	logic [1:0] sz = 2'h0;
	logic [31:0] a = 32'h0, wd = 32'h0, prd, rd, tg32, q;
	logic [14:0] la = 15'h0;
	logic [15:0] ldat = 16'h0;
	logic rdy, dn, faz, ahb, apb, pwr;
	logic [2:0] tg;
	logic [3:0] pbe;
	logic [31:0] pa, pwd;
	int errors = 0, num_checks = 0, cycles = 0, n;
	memmap_decoder uut (.CLK_I(clk), .RESET_I(rst), .REQ_I(req), .ADDR_I(a), .WRITE_I(wr),
		.SIZE_I(sz), .WDATA_I(wd), .PER_RDATA_I(prd), .FLASH_LOAD_I(ld),
		.FLASH_LOAD_ADDR_I(la), .FLASH_LOAD_DATA_I(ldat), .FLASH_BOOT_UNLOCK_I(unl),
		.READY_O(rdy), .DONE_O(dn), .RDATA_O(rd), .TARGET_O(tg), .FLASH_AT_ZERO_O(faz),
		.AHB_REQ_O(ahb), .APB_REQ_O(apb), .PER_ADDR_O(pa), .PER_WRITE_O(pwr),
		.PER_BE_O(pbe), .PER_WDATA_O(pwd));
	periph_model pm (.clk_i(clk), .ahb_req_i(ahb), .apb_req_i(apb), .addr_i(pa), .rdata_o(prd));
	always #25 clk = ~clk;
	assign tg32 = {29'h0, tg};
	////////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			errors++;
			tally_and_finish;
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// one access; n counts edges from take to the done cycle
	task automatic acc(input logic w, input logic [1:0] s, input logic [31:0] ad, d);
		@(posedge clk);
		#1;
		req = 1'b1;
		wr = w;
		sz = s;
		a = ad;
		wd = d;
		@(posedge clk);
		#1;
		req = 1'b0;
		n = 1;
		while (dn !== 1'b1 && n < 9)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		q = rd;
	endtask
	task automatic load(input logic [14:0] i, input logic [15:0] v);
		@(posedge clk);
		#1;
		ld = 1'b1;
		la = i;
		ldat = v;
		@(posedge clk);
		#1;
		ld = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////
	task automatic t_flash;
		load(15'h0, 16'h1234);
		load(15'h1, 16'habcd);
		acc(1'b0, 2'h2, 32'h0010_0000, 32'h0);
		chk("flash word", q, 32'habcd_1234);
		chk("flash word edges", 32'(n), 32'h2);
		chk("flash target", tg32, 32'h2);
		acc(1'b0, 2'h2, 32'h0010_0002, 32'h0);
		chk("flash word aligned", q, 32'habcd_1234);
		acc(1'b0, 2'h1, 32'h0010_0002, 32'h0);
		chk("flash half", q, 32'habcd);
		chk("flash half edges", 32'(n), 32'h1);
		acc(1'b0, 2'h0, 32'h0010_0003, 32'h0);
		chk("flash byte", q, 32'hab);
		acc(1'b1, 2'h2, 32'h0010_0000, 32'hffff_ffff);
		acc(1'b0, 2'h2, 32'h0, 32'h0);
		chk("zero alias flash", q, 32'habcd_1234);
	endtask
	task automatic t_sram;
		acc(1'b1, 2'h2, 32'h0020_0004, 32'h1122_3344);
		acc(1'b1, 2'h0, 32'h0020_0005, 32'h0000_00ee);
		chk("sram edges", 32'(n), 32'h1);
		acc(1'b0, 2'h2, 32'h0020_0004, 32'h0);
		chk("sram lanes", q, 32'h1122_ee44);
		acc(1'b0, 2'h1, 32'h0020_0006, 32'h0);
		chk("sram half", q, 32'h1122);
		acc(1'b0, 2'h2, 32'h0030_0000, 32'h0);
		chk("unmapped data", q, 32'h0);
		chk("unmapped target", tg32, 32'h0);
	endtask
	task automatic t_remap;
		acc(1'b0, 2'h0, 32'hffff_0220, 32'h0);
		chk("remap reset", q, 32'h0);
		chk("remap edges", 32'(n), 32'h3);
		acc(1'b1, 2'h0, 32'hffff_0220, 32'h0);
		chk("remap flag", {31'h0, faz}, 32'h0);
		acc(1'b0, 2'h2, 32'h0000_0004, 32'h0);
		chk("zero alias sram", q, 32'h1122_ee44);
		acc(1'b1, 2'h0, 32'hffff_0220, 32'h1);
		acc(1'b0, 2'h2, 32'h0, 32'h0);
		chk("alias back", q, 32'habcd_1234);
	endtask
	// only occupied register locations are touched
	task automatic t_periph;
		acc(1'b0, 2'h2, 32'hffff_f400, 32'h0);
		chk("ahb data", q, 32'ha5a5_f400);
		chk("ahb edges", 32'(n), 32'h2);
		chk("ahb target", tg32, 32'h4);
		chk("ahb released", {30'h0, ahb, apb}, 32'h0);
		chk("ready back", {31'h0, rdy}, 32'h1);
		acc(1'b0, 2'h2, 32'hffff_0300, 32'h0);
		chk("apb data", q, 32'ha5a5_0300);
		chk("apb edges", 32'(n), 32'h3);
		acc(1'b1, 2'h0, 32'hffff_0301, 32'h5c);
		chk("apb target", tg32, 32'h5);
		chk("apb lanes", {28'h0, pbe}, 32'h2);
		chk("apb byte", {24'h0, pwd[15:8]}, 32'h5c);
		chk("apb write", {31'h0, pwr}, 32'h1);
		chk("apb addr", pa, 32'hffff_0301);
	endtask
	task automatic t_boot;
		unl = 1'b1;
		load(15'd32767, 16'h0f0f);
		unl = 1'b0;
		load(15'd32767, 16'hdead);
		load(15'd31743, 16'h7e7e);
		acc(1'b0, 2'h1, 32'h0010_fffe, 32'h0);
		chk("boot locked", q, 32'h0f0f);
		acc(1'b0, 2'h1, 32'h0010_f7fe, 32'h0);
		chk("user top", q, 32'h7e7e);
	endtask
	// a reset in mid-run must bring flash back to zero and clear the stored byte
	task automatic t_reset;
		acc(1'b1, 2'h0, 32'hffff_0220, 32'h2);
		chk("remap before reset", {31'h0, faz}, 32'h0);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		rst = 1'b0;
		chk("rearm alias", {31'h0, faz}, 32'h1);
		chk("rearm ready", {31'h0, rdy}, 32'h1);
		acc(1'b0, 2'h0, 32'hffff_0220, 32'h0);
		chk("remap after reset", q, 32'h0);
		acc(1'b0, 2'h2, 32'h0, 32'h0);
		chk("alias after reset", q, 32'habcd_1234);
	endtask
	////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (8) @(posedge clk);
		#1;
		chk("reset ready", {31'h0, rdy}, 32'h1);
		chk("reset alias", {31'h0, faz}, 32'h1);
		rst = 1'b0;
		t_flash;
		t_sram;
		t_remap;
		t_periph;
		t_boot;
		t_reset;
		tally_and_finish;
	end
endmodule

//--- logic/memmap_cfg.svh
// address map constants for the memory map decoder
// assumes a 32-bit byte address from the core
`ifndef MEMMAP_CFG_SVH
`define MEMMAP_CFG_SVH
`define MM_ZERO_HI 16'h0000
`define MM_PERIPH_HI 16'hffff
`define MM_AHB_NIB 4'hf
`define MM_REMAP_ADDR 32'hffff0220
`define MM_REMAP_RST 8'h00
`define MM_FLASH_BASE 32'h0010_0000
`define MM_SRAM_BASE 32'h0020_0000
`define MM_FLASH_WORDS 32768
`define MM_BOOT_WORDS 1024
`define MM_SRAM_WORDS 2048
`endif

//--- logic/memmap_decoder.sv
// memory map decoder with sram, 16-bit flash array and remap control
// assumes one request at a time from the core, taken while READY_O is high
`timescale 1ns/10ps
`include "memmap_cfg.svh"

////////////////////////////////////////////////////////////////////////
module memmap_decoder #(
	parameter int FLASH_WORDS = `MM_FLASH_WORDS,
	parameter int BOOT_WORDS = `MM_BOOT_WORDS,
	parameter int SRAM_WORDS = `MM_SRAM_WORDS
) (
	input wire logic CLK_I,
	input wire logic RESET_I,
	input wire logic REQ_I,
	input wire logic [31:0] ADDR_I,
	input wire logic WRITE_I,
	input wire logic [1:0] SIZE_I,
	input wire logic [31:0] WDATA_I,
	input wire logic [31:0] PER_RDATA_I,
	input wire logic FLASH_LOAD_I,
	input wire logic [14:0] FLASH_LOAD_ADDR_I,
	input wire logic [15:0] FLASH_LOAD_DATA_I,
	input wire logic FLASH_BOOT_UNLOCK_I,
	output logic READY_O,
	output logic DONE_O,
	output logic [31:0] RDATA_O,
	output logic [2:0] TARGET_O,
	output logic FLASH_AT_ZERO_O,
	output logic AHB_REQ_O,
	output logic APB_REQ_O,
	output logic [31:0] PER_ADDR_O,
	output logic PER_WRITE_O,
	output logic [3:0] PER_BE_O,
	output logic [31:0] PER_WDATA_O
);

	typedef struct packed {
		memmap_pkg::state_t st;
		memmap_pkg::target_t tgt;
		logic ready;
		logic done;
		logic [31:0] rdata;
		logic [7:0] remap;
		logic flash_zero;
		logic ahb;
		logic apb;
		logic [31:0] addr;
		logic wr;
		logic [3:0] be;
		logic [31:0] wdata;
		logic [1:0] size;
	} regs_t;

	regs_t s_q;
	regs_t s_d;
	logic [31:0] sram [SRAM_WORDS];
	logic [15:0] flash [FLASH_WORDS];
	memmap_pkg::target_t tgt_c;
	logic [15:0] fl_off_c;
	logic [12:0] sr_off_c;
	logic acc;
	logic [31:0] sram_w;
	logic [31:0] fl_lo;
	logic [31:0] fl_hi;
	logic [3:0] be_c;
	logic [31:0] wd_c;

	////////////////////////////////////////////////////////////////////
	// lane helpers, shared by sram, register and peripheral paths

	function automatic logic [1:0] lane(input logic [1:0] sz, input logic [1:0] a);
		lane = (sz == memmap_pkg::SZ_BYTE) ? a : (sz == memmap_pkg::SZ_HALF) ? {a[1], 1'b0} : 2'h0;
	endfunction

	function automatic logic [3:0] lane_be(input logic [1:0] sz, input logic [1:0] a);
		logic [3:0] m;
		m = (sz == memmap_pkg::SZ_BYTE) ? 4'h1 : (sz == memmap_pkg::SZ_HALF) ? 4'h3 : 4'hf;
		lane_be = m << lane(sz, a);
	endfunction

	function automatic logic [31:0] put_lanes(input logic [1:0] sz, input logic [1:0] a,
		input logic [31:0] d);
		put_lanes = d << {lane(sz, a), 3'h0};
	endfunction

	function automatic logic [31:0] get_lanes(input logic [1:0] sz, input logic [1:0] a,
		input logic [31:0] w);
		logic [31:0] x;
		x = w >> {lane(sz, a), 3'h0};
		get_lanes = (sz == memmap_pkg::SZ_BYTE) ? {24'h0, x[7:0]} :
			(sz == memmap_pkg::SZ_HALF) ? {16'h0, x[15:0]} : x;
	endfunction

	////////////////////////////////////////////////////////////////////
	// address decode; the zero mirror follows the stored alias flag

	always_comb
	begin
		tgt_c = memmap_pkg::T_NONE;
		// words align down so both halves of one word pair up
		fl_off_c = (SIZE_I == memmap_pkg::SZ_WORD) ? {ADDR_I[15:2], 2'h0} : ADDR_I[15:0];
		sr_off_c = ADDR_I[12:0];
		if (ADDR_I[31:16] == `MM_ZERO_HI)
			tgt_c = s_q.flash_zero ? memmap_pkg::T_FLASH : memmap_pkg::T_SRAM;
		else if (ADDR_I[31:16] == 16'(`MM_FLASH_BASE >> 16))
			tgt_c = memmap_pkg::T_FLASH;
		else if (ADDR_I[31:13] == 19'(`MM_SRAM_BASE >> 13))
			tgt_c = memmap_pkg::T_SRAM;
		else if (ADDR_I == `MM_REMAP_ADDR)
			tgt_c = memmap_pkg::T_REG;
		else if (ADDR_I[31:16] == `MM_PERIPH_HI)
			tgt_c = (ADDR_I[15:12] == `MM_AHB_NIB) ? memmap_pkg::T_AHB : memmap_pkg::T_APB;
	end

	assign acc = REQ_I && (s_q.st == memmap_pkg::S_IDLE);
	assign be_c = lane_be(SIZE_I, ADDR_I[1:0]);
	assign wd_c = put_lanes(SIZE_I, ADDR_I[1:0], WDATA_I);
	assign sram_w = sram[sr_off_c[12:2]];
	assign fl_lo = {2{flash[fl_off_c[15:1]]}};
	assign fl_hi = {flash[{s_q.addr[15:2], 1'b1}], 16'h0};

	////////////////////////////////////////////////////////////////////
	// memories; core writes to flash are dropped, only the load port programs it

	always_ff @(posedge CLK_I)
	begin
		if (acc && WRITE_I && tgt_c == memmap_pkg::T_SRAM)
		begin
			for (int i = 0; i < 4; i++)
				if (be_c[i])
					sram[sr_off_c[12:2]][i*8 +: 8] <= wd_c[i*8 +: 8];
		end
		// boot page locked unless unlocked, keeps user loads out of the kernel page
		if (FLASH_LOAD_I && (FLASH_LOAD_ADDR_I < 15'(FLASH_WORDS - BOOT_WORDS)
			|| FLASH_BOOT_UNLOCK_I))
			flash[FLASH_LOAD_ADDR_I] <= FLASH_LOAD_DATA_I;
	end

	////////////////////////////////////////////////////////////////////
	// access sequencer

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		case (s_q.st)
			memmap_pkg::S_IDLE:
			begin
				if (acc)
				begin
					s_d.tgt = tgt_c;
					s_d.addr = ADDR_I;
					s_d.wr = WRITE_I;
					s_d.be = be_c;
					s_d.wdata = wd_c;
					s_d.size = SIZE_I;
					s_d.rdata = 32'h0;
					case (tgt_c)
						memmap_pkg::T_SRAM:
						begin
							s_d.done = 1'b1;
							if (!WRITE_I)
								s_d.rdata = get_lanes(SIZE_I, ADDR_I[1:0], sram_w);
						end
						memmap_pkg::T_FLASH:
						begin
							if (!WRITE_I && SIZE_I == memmap_pkg::SZ_WORD)
							begin
								// first half now, upper half next cycle
								s_d.rdata = {16'h0, fl_lo[15:0]};
								s_d.st = memmap_pkg::S_LAST;
							end
							else
							begin
								s_d.done = 1'b1;
								if (!WRITE_I)
									s_d.rdata = get_lanes(SIZE_I, ADDR_I[1:0], fl_lo);
							end
						end
						memmap_pkg::T_REG:
						begin
							// byte register: lane 0 of its word
							if (WRITE_I && be_c[0])
							begin
								s_d.remap = wd_c[7:0];
								s_d.flash_zero = wd_c[0];
							end
							else if (!WRITE_I)
								s_d.rdata = {24'h0, s_q.remap};
							s_d.st = memmap_pkg::S_WAIT;
						end
						memmap_pkg::T_AHB:
						begin
							s_d.ahb = 1'b1;
							s_d.st = memmap_pkg::S_LAST;
						end
						memmap_pkg::T_APB:
						begin
							s_d.apb = 1'b1;
							s_d.st = memmap_pkg::S_WAIT;
						end
						default:
							s_d.done = 1'b1; // unmapped reads zero, writes vanish
					endcase
				end
			end
			memmap_pkg::S_WAIT:
				s_d.st = memmap_pkg::S_LAST;
			memmap_pkg::S_LAST:
			begin
				s_d.st = memmap_pkg::S_IDLE;
				s_d.done = 1'b1;
				s_d.ahb = 1'b0;
				s_d.apb = 1'b0;
				if (s_q.tgt == memmap_pkg::T_FLASH)
					s_d.rdata = s_q.rdata | fl_hi;
				else if (!s_q.wr && (s_q.ahb || s_q.apb))
					s_d.rdata = get_lanes(s_q.size, s_q.addr[1:0], PER_RDATA_I);
			end
			default:
				s_d.st = memmap_pkg::S_IDLE;
		endcase
		s_d.ready = (s_d.st == memmap_pkg::S_IDLE);
	end

	always_ff @(posedge CLK_I or posedge RESET_I)
	begin
		if (RESET_I)
		begin
			s_q <= '0;
			s_q.st <= memmap_pkg::S_IDLE;
			s_q.tgt <= memmap_pkg::T_NONE;
			s_q.ready <= 1'b1;
			s_q.remap <= `MM_REMAP_RST;
			s_q.flash_zero <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign READY_O = s_q.ready;
	assign DONE_O = s_q.done;
	assign RDATA_O = s_q.rdata;
	assign TARGET_O = s_q.tgt;
	assign FLASH_AT_ZERO_O = s_q.flash_zero;
	assign AHB_REQ_O = s_q.ahb;
	assign APB_REQ_O = s_q.apb;
	assign PER_ADDR_O = s_q.addr;
	assign PER_WRITE_O = s_q.wr;
	assign PER_BE_O = s_q.be;
	assign PER_WDATA_O = s_q.wdata;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge CLK_I); endclocking
	default disable iff (RESET_I);

	a_alias_clear: assert property ($fell(FLASH_AT_ZERO_O) |->
		$past(acc && tgt_c == memmap_pkg::T_REG && WRITE_I && !WDATA_I[0]))
		else $error("flash alias dropped without remap write");
	a_zero_target: assert property (acc && ADDR_I[31:16] == `MM_ZERO_HI |=>
		TARGET_O == (($past(FLASH_AT_ZERO_O)) ? memmap_pkg::T_FLASH : memmap_pkg::T_SRAM))
		else $error("zero region sent to wrong memory");
	a_ahb_one: assert property ($rose(AHB_REQ_O) |=> DONE_O && !AHB_REQ_O)
		else $error("ahb access not one cycle");
	a_apb_two: assert property ($rose(APB_REQ_O) |-> APB_REQ_O [*2] ##1
		(DONE_O && !APB_REQ_O))
		else $error("apb access not two cycles");
	a_one_bus: assert property ($onehot0({AHB_REQ_O, APB_REQ_O}))
		else $error("two buses selected");
	a_flash_word: assert property (acc && tgt_c == memmap_pkg::T_FLASH && !WRITE_I &&
		SIZE_I == memmap_pkg::SZ_WORD |=> !DONE_O ##1 DONE_O)
		else $error("flash word not two accesses");
	a_sram_single: assert property (acc && tgt_c == memmap_pkg::T_SRAM |=> DONE_O)
		else $error("sram access not single cycle");
	a_route_ahb: assert property (acc && ADDR_I[31:16] == `MM_PERIPH_HI &&
		ADDR_I[15:12] == `MM_AHB_NIB |=> AHB_REQ_O)
		else $error("ahb peripheral misrouted");
	a_periph_top: assert property (AHB_REQ_O || APB_REQ_O |->
		PER_ADDR_O[31:16] == `MM_PERIPH_HI)
		else $error("peripheral access outside top pages");
	a_byte_lane: assert property (acc && SIZE_I == memmap_pkg::SZ_BYTE |=>
		$countones(PER_BE_O) == 1)
		else $error("byte access touches several lanes");

endmodule

//--- logic/memmap_pkg.sv
// types shared by the memory map decoder
// assumes nothing of its surroundings
package memmap_pkg;
	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0,
		SZ_HALF = 2'h1,
		SZ_WORD = 2'h2
	} size_t;
	typedef enum logic [2:0] {
		T_NONE = 3'h0,
		T_SRAM = 3'h1,
		T_FLASH = 3'h2,
		T_REG = 3'h3,
		T_AHB = 3'h4,
		T_APB = 3'h5
	} target_t;
	typedef enum logic [1:0] {
		S_IDLE = 2'h0,
		S_WAIT = 2'h1,
		S_LAST = 2'h2
	} state_t;
endpackage
